// ### core/rsptr_map.svh
/*
 * Register map for the signal strength, amplifier bias and trim register group.
 * Assumes an 8-bit register address and 8-bit data path from the serial front end.
 */
// Overview of operation
// (R1) Strength register read-only, top bits reserved zero
// (R2) Bit 5 flags strength value valid
// (R3) Low five bits hold strength, larger stronger
// (R4) One strength sample per receive entry
// (R5) Three-bit amplifier bias, larger gives more power
// (R6) Software should set bias to seven
// (R7) Software writes zeros to reserved bits
// (R8) Bit 6 set stops reference clock output
// (R9) Software disables clock output when unused
// (R10) Six-bit crystal load trim field
// (R11) Slope field: 11 wide, 10 narrow, 00 off
// (R12) Slope field write-only, reads undefined
// (R13) Software programs wide slope at start
// (R14) Self-clearing device reset restores all defaults
// (R15) Registers reached over serial register port
`ifndef RSPTR_MAP_SVH
`define RSPTR_MAP_SVH

// ****************************************
// Offsets
// ****************************************
`define RSPTR_ADDR_STRENGTH  8'h22
`define RSPTR_ADDR_BIAS      8'h23
`define RSPTR_ADDR_XTAL      8'h24
`define RSPTR_ADDR_SLOPE     8'h26

// ****************************************
// Field positions and reset values
// ****************************************
`define RSPTR_VALID_BIT      5
`define RSPTR_CLKDIS_BIT     6
`define RSPTR_SLOPE_LSB      6
`define RSPTR_RST_STRENGTH   8'h00
`define RSPTR_RST_BIAS       3'h0
`define RSPTR_RST_XTAL       7'h00
`define RSPTR_RST_SLOPE      2'h0
// Value returned for undefined slope bits and unmapped reads
`define RSPTR_READ_FILL      8'h00

`endif

// ### core/rsptr_pkg.sv
/*
 * Types for the signal strength and trim register group.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rsptr_pkg;

    // Register port request from the serial front end
    typedef struct packed {
        logic       wr;     // One-cycle write strobe
        logic       rd;     // One-cycle read strobe
        logic [7:0] addr;   // Register address
        logic [7:0] wdata;  // Write data
    } rsptr_req_t;

    // Oscillator slope setting
    typedef enum logic [1:0] {
        RSPTR_SLOPE_OFF    = 2'b00,
        RSPTR_SLOPE_RSVD   = 2'b01,
        RSPTR_SLOPE_NARROW = 2'b10,
        RSPTR_SLOPE_WIDE   = 2'b11
    } rsptr_slope_t;

    // Analog trim outputs
    typedef struct packed {
        logic [2:0]   amp_bias;     // Transmit amplifier bias
        logic [5:0]   xtal_trim;    // Crystal load trim
        logic         clk_out_en;   // Reference clock output enable
        logic         slope_en;     // Slope adjust active
        logic         slope_wide;   // Wide range when active
    } rsptr_trim_t;

endpackage

// ### core/rsptr_sample.sv
/*
 * Strength sampler: captures one strength sample per entry into receive mode.
 * Assumes the analog strength value is synchronous to sys_clk.
 */
`timescale 1ns/1ns
`default_nettype none
`include "rsptr_map.svh"

module rsptr_sample (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       soft_rst,
    // Receive mode and measurement
    input  wire logic       rx_mode,
    input  wire logic [4:0] strength_in,
    // Captured result
    output logic [5:0]      sample_q
);
    // ****************************************
    // Receive entry detect
    // ****************************************
    logic rx_mode_q;            // Previous receive mode
    wire  rx_entry = rx_mode & ~rx_mode_q;

    // Capture only on the entry edge; staying in receive never resamples
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_mode_q <= 1'b0;
            sample_q  <= 6'h00;
        end
        else if (soft_rst)
        begin
            rx_mode_q <= 1'b0;
            sample_q  <= 6'h00;                 // R14
        end
        else
        begin
            rx_mode_q <= rx_mode;
            if (rx_entry)
                sample_q <= {1'b1, strength_in}; // R4 R2 R3
        end
    end

    // A sample of the strength at entry is taken on every entry
    a_one_sample: assert property (@(posedge sys_clk) disable iff (!rst_n || soft_rst) // R4
        rx_entry |=> (sample_q == {1'b1, $past(strength_in)}))
        else $error("strength not captured on receive entry");
endmodule
`default_nettype wire

// ### core/rsptr_regs.sv
/*
 * Register group: signal strength status, transmit amplifier bias,
 * crystal trim with reference clock disable, and oscillator slope.
 * Assumes the serial front end presents decoded one-cycle read and write strobes
 * synchronous to sys_clk, and samples read data in the cycle after a read strobe.
 */
`timescale 1ns/1ns
`default_nettype none
`include "rsptr_map.svh"

module rsptr_regs
    import rsptr_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // Self-clearing device reset pulse from the analog control register
    input  wire logic       soft_rst,
    // Register port
    input  var  rsptr_pkg::rsptr_req_t req,
    output logic [7:0]      rdata_q,
    // Receiver status
    input  wire logic       rx_mode,
    input  wire logic [4:0] strength_in,
    // Analog controls
    output rsptr_pkg::rsptr_trim_t trim_q,
    output logic            ref_clock_out_pin
);
    import rsptr_pkg::*;

    // ****************************************
    // Storage
    // ****************************************
    logic [2:0]   bias_q;       // Amplifier bias field
    logic [6:0]   xtal_q;       // Clock disable and load trim
    rsptr_slope_t slope_q;      // Write-only slope field
    logic [5:0]   sample;       // Valid flag and strength
    logic         ref_clk_q;    // Divided reference clock source
    // The strength register lives in the sampler; no write path reaches it

    // ****************************************
    // Decode
    // ****************************************
    wire hit_bias  = req.addr == `RSPTR_ADDR_BIAS;
    wire hit_xtal  = req.addr == `RSPTR_ADDR_XTAL;
    wire hit_slope = req.addr == `RSPTR_ADDR_SLOPE;
    wire hit_str   = req.addr == `RSPTR_ADDR_STRENGTH;
    // No register answers: reads return the fill value, writes are dropped
    wire hit_none  = ~(hit_bias | hit_xtal | hit_slope | hit_str);

    // Writes to the strength address are dropped: it is read-only
    wire wr_bias  = req.wr & hit_bias;                  // R15
    wire wr_xtal  = req.wr & hit_xtal;                  // R15
    wire wr_slope = req.wr & hit_slope;                 // R15

    // Read mux; slope bits are undefined and read as fill value
    wire [7:0] rd_mux =
        hit_str   ? {2'b00, sample}      :              // R1
        hit_bias  ? {5'b00000, bias_q}   :
        hit_xtal  ? {1'b0, xtal_q}       :
        hit_slope ? `RSPTR_READ_FILL     :              // R12
                    `RSPTR_READ_FILL;

    // ****************************************
    // Strength capture
    // ****************************************
    rsptr_sample u_sample (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .soft_rst    (soft_rst),
        .rx_mode     (rx_mode),
        .strength_in (strength_in),
        .sample_q    (sample)
    );

    // ****************************************
    // Writable registers
    // ****************************************
    // Soft reset wins over a write in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bias_q  <= `RSPTR_RST_BIAS;
            xtal_q  <= `RSPTR_RST_XTAL;
            slope_q <= RSPTR_SLOPE_OFF;
        end
        else if (soft_rst)
        begin
            bias_q  <= `RSPTR_RST_BIAS;                   // R14
            xtal_q  <= `RSPTR_RST_XTAL;                   // R14
            slope_q <= RSPTR_SLOPE_OFF;                   // R14
        end
        else
        begin
            if (wr_bias)
                bias_q <= req.wdata[2:0];                 // R5
            if (wr_xtal)
                xtal_q <= req.wdata[6:0];                 // R8 R10
            if (wr_slope)
                slope_q <= rsptr_slope_t'(req.wdata[7:`RSPTR_SLOPE_LSB]); // R11
        end
    end

    // ****************************************
    // Read data and trim outputs
    // ****************************************
    // Read data is loaded only by a read strobe, so it stands until the
    // next read and the serial side may shift it out at its own pace
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_q <= 8'h00;
        else if (req.rd)
            rdata_q <= rd_mux;
    end

    // Reserved slope code 01 is treated as off to stay safe
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            trim_q <= '0;
        else
        begin
            trim_q.amp_bias   <= bias_q;                  // R5
            trim_q.xtal_trim  <= xtal_q[5:0];             // R10
            trim_q.clk_out_en <= ~xtal_q[`RSPTR_CLKDIS_BIT]; // R8
            trim_q.slope_en   <= slope_q[1];              // R11
            trim_q.slope_wide <= slope_q == RSPTR_SLOPE_WIDE; // R11
        end
    end

    // ****************************************
    // Reference clock output
    // ****************************************
    // Half-rate toggle stands in for the buffered reference; held low when disabled
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            ref_clk_q <= 1'b0;
        else
            ref_clk_q <= ~ref_clk_q;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            ref_clock_out_pin <= 1'b0;
        else
            ref_clock_out_pin <= ref_clk_q & ~xtal_q[`RSPTR_CLKDIS_BIT]; // R8
    end

    // ****************************************
    // Checks
    // ****************************************
    a_strength_ro: assert property (@(posedge sys_clk) disable iff (!rst_n) // R1
        (req.rd && hit_str) |=> (rdata_q[7:6] == 2'b00))
        else $error("strength reserved bits not zero");

    a_valid_flag: assert property (@(posedge sys_clk) disable iff (!rst_n) // R2
        (req.rd && hit_str) |=> (rdata_q[5:0] == $past(sample)))
        else $error("strength read data wrong");

    a_bias_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // R5
        (wr_bias && !soft_rst) |=> ##1 (trim_q.amp_bias == $past(req.wdata[2:0], 2)))
        else $error("bias not applied");

    a_clk_disable: assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
        xtal_q[`RSPTR_CLKDIS_BIT] && $past(xtal_q[`RSPTR_CLKDIS_BIT]) |-> !ref_clock_out_pin)
        else $error("reference clock driven while disabled");

    a_xtal_trim: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
        (wr_xtal && !soft_rst) |=> ##1 (trim_q.xtal_trim == $past(req.wdata[5:0], 2)))
        else $error("crystal trim not applied");

    a_slope_wide: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
        (wr_slope && !soft_rst && req.wdata[7:6] == 2'b11) |=> ##1
        (trim_q.slope_en && trim_q.slope_wide))
        else $error("wide slope not decoded");

    a_slope_hidden: assert property (@(posedge sys_clk) disable iff (!rst_n) // R12
        (req.rd && hit_slope) |=> (rdata_q == `RSPTR_READ_FILL))
        else $error("slope field leaked on read");

    a_soft_reset: assert property (@(posedge sys_clk) disable iff (!rst_n) // R14
        soft_rst |=> (bias_q == 3'h0 && xtal_q == 7'h00 && slope_q == RSPTR_SLOPE_OFF
        && sample == 6'h00))
        else $error("soft reset left a register set");

    // A device reset clears the sample legitimately, so it is left out here
    a_ro_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // R15
        (req.wr && hit_str && !rx_mode && !soft_rst) |=> $stable(sample))
        else $error("write changed strength register");

    // ****************************************
    // Read-back and decode checks
    // ****************************************
    // Read data must come from the stored field, not from the write path
    a_bias_read: assert property (@(posedge sys_clk) disable iff (!rst_n) // R5
        (req.rd && hit_bias) |=> (rdata_q == {5'h00, $past(bias_q)}))
        else $error("bias read-back wrong");

    a_xtal_read: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
        (req.rd && hit_xtal) |=> (rdata_q == {1'b0, $past(xtal_q)}))
        else $error("crystal trim read-back wrong");

    // Unmapped addresses must not alias onto a real register
    a_unmapped_read: assert property (@(posedge sys_clk) disable iff (!rst_n) // R15
        (req.rd && hit_none) |=> (rdata_q == `RSPTR_READ_FILL))
        else $error("unmapped read returned data");

    // Narrow code enables the adjust without the wide range
    a_slope_narrow: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
        (wr_slope && !soft_rst && req.wdata[7:6] == 2'b10) |=> ##1
        (trim_q.slope_en && !trim_q.slope_wide))
        else $error("narrow slope not decoded");

    // Off and reserved codes both leave the adjust idle
    a_slope_off: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
        (wr_slope && !soft_rst && !req.wdata[7]) |=> ##1
        (!trim_q.slope_en && !trim_q.slope_wide))
        else $error("slope adjust active for off code");

    // An enabled pin must toggle; a pin stuck low would pass the disable check
    a_clk_toggle: assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
        (trim_q.clk_out_en && $past(trim_q.clk_out_en))
        |-> (ref_clock_out_pin != $past(ref_clock_out_pin)))
        else $error("reference clock not toggling while enabled");
endmodule
`default_nettype wire

// ### bench/rsptr_mcu.sv
/*
 * Controller model that drives the register port of the trim register group.
 * Assumes callers run in the testbench at a falling edge of sys_clk.
 */
`timescale 1ns/1ns
`default_nettype none

module rsptr_mcu (
    // Clock
    input  wire logic             sys_clk,
    // Register port towards the block
    output var rsptr_pkg::rsptr_req_t req
);
    import rsptr_pkg::*;

    // Reserved bits of the bias, trim and slope registers are sent as zero
    function automatic logic [7:0] clean(input logic [7:0] a, input logic [7:0] d);
        case (a)
            8'h23:   clean = d & 8'h07;
            8'h24:   clean = d & 8'h7f;
            8'h26:   clean = d & 8'hc0;
            default: clean = d;
        endcase
    endfunction

    initial req = '0;

    // One-cycle strobe; the idle bus shows inverted junk, not the last value
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        req = '{wr: w, rd: ~w, addr: a, wdata: clean(a, d)};
        @(negedge sys_clk);
        req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~req.wdata};
    endtask

    // Start-up programming
    task automatic init();
        xfer(1'b1, 8'h23, 8'h07);
        xfer(1'b1, 8'h26, 8'hc0);
        xfer(1'b1, 8'h24, 8'h40);
    endtask
endmodule

`default_nettype wire

// ### bench/testbench.sv
/*
 * Self-checking bench for the trim register group.
 * Assumes the controller model drives the port; reads land one cycle later.
 */
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import rsptr_pkg::*;

    // ********************
    // Signals
    // ********************
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        soft_rst = 1'b0;
    logic        rx_mode = 1'b0;
    logic [4:0]  strength_in = 5'h00;
    logic        rd_d = 1'b0;
    rsptr_req_t  req;
    logic [7:0]  rdata_q;
    rsptr_trim_t trim_q;
    logic        ref_clock_out_pin;
    logic [7:0]  exp_q[$];
    logic [2:0]  bias_e = 3'h0;
    logic [6:0]  xtal_e = 7'h00;
    logic [1:0]  slope_e = 2'h0;
    logic [4:0]  s;
    int          n_errors = 0;
    int          checks_done = 0;
    int          seed = 54822;

    always #50 sys_clk = ~sys_clk;

    rsptr_mcu i_mcu (.sys_clk(sys_clk), .req(req));
    rsptr_regs i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .soft_rst(soft_rst), .req(req),
        .rdata_q(rdata_q), .rx_mode(rx_mode), .strength_in(strength_in), .trim_q(trim_q),
        .ref_clock_out_pin(ref_clock_out_pin));

    // ********************
    // Compare and report
    // ********************
    task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t rd got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_out(input logic [11:0] got, input logic [11:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t out got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (exp_q.size() != 0)
            n_errors++;
        $display("errors=%0d checks=%0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Expected analog controls from the shadow copies
    function automatic rsptr_trim_t trim_e();
        trim_e = {bias_e, xtal_e[5:0], ~xtal_e[6], slope_e[1], &slope_e};
    endfunction

    // Reads note their result first; writes wait until trim_q has settled
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_mcu.xfer(1'b0, a, 8'h00);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_mcu.xfer(1'b1, a, d);
        repeat (2) @(negedge sys_clk);
    endtask

    // Reference clock toggles each cycle while enabled, low otherwise
    task automatic pin_chk(input logic on);
        logic p;
        p = ref_clock_out_pin;
        @(negedge sys_clk);
        cmp_out({11'h000, ref_clock_out_pin}, {11'h000, on & ~p});
    endtask

    task automatic rd_all(input logic [7:0] st);
        rd(8'h22, st);
        rd(8'h23, {5'h00, bias_e});
        rd(8'h24, {1'b0, xtal_e});
        rd(8'h26, 8'h00);
        rd(8'h25, 8'h00);
        cmp_out(trim_q, trim_e());
    endtask

    // Result watcher pairs each read with the oldest note
    always @(posedge sys_clk) rd_d <= req.rd && rst_n;
    always @(negedge sys_clk)
        if (rd_d)
            cmp_rd(rdata_q, exp_q.pop_front());

    // Hang guard
    initial
    begin
        repeat (5000) @(negedge sys_clk);
        n_errors++;
        tally_and_finish();
    end

    // ********************
    // Main sequence
    // ********************
    initial
    begin
        repeat (20) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        rd_all(8'h00);
        pin_chk(1'b1);
        i_mcu.init();
        repeat (2) @(negedge sys_clk);
        bias_e = 3'h7;
        slope_e = 2'h3;
        xtal_e = 7'h40;
        rd_all(8'h00);
        pin_chk(1'b0);
        // Random bias, trim and clock disable
        repeat (8)
        begin
            bias_e = 3'($random(seed));
            xtal_e = 7'($random(seed));
            wr(8'h23, {5'h00, bias_e});
            wr(8'h24, {1'b0, xtal_e});
            cmp_out(trim_q, trim_e());
            pin_chk(~xtal_e[6]);
        end
        // Every slope code
        for (int c = 0; c < 4; c++)
        begin
            slope_e = 2'(c);
            wr(8'h26, {slope_e, 6'h00});
            cmp_out(trim_q, trim_e());
            rd(8'h26, 8'h00);
        end
        wr(8'h22, 8'hff);
        rd(8'h22, 8'h00);
        // One sample per receive entry, later changes ignored
        repeat (4)
        begin
            s = 5'($random(seed));
            strength_in = s;
            rx_mode = 1'b1;
            repeat (2) @(negedge sys_clk);
            strength_in = ~s;
            rd(8'h22, {2'b00, 1'b1, s});
            rx_mode = 1'b0;
            @(negedge sys_clk);
        end
        // Device reset pulse restores defaults
        soft_rst = 1'b1;
        @(negedge sys_clk);
        soft_rst = 1'b0;
        bias_e = 3'h0;
        xtal_e = 7'h00;
        slope_e = 2'h0;
        rd_all(8'h00);
        pin_chk(1'b1);
        tally_and_finish();
    end
endmodule

`default_nettype wire
